// file: chip_select_pkg.sv
/*
 Constants, encodings, carrier types and helper functions for the
 foreign-master chip-select block.
 Assumes one 100 MHz core clock and an 8-bit byte-addressed register port.
*/
package chip_select_pkg;

	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam int BANK_COUNT = 8;
	localparam int BANK_IDX_BITS = 3;
	localparam logic [3:0] BASE_OFS = 4'h0;
	localparam logic [3:0] MASK_OFS = 4'h4;
	localparam logic [3:0] CTRL_OFS = 4'h8;
	localparam logic [7:0] DFLT_OFS = 8'h80;
	localparam logic [7:0] PIN_OFS = 8'h84;
	localparam logic [7:0] STATUS_OFS = 8'h88;
	localparam int MASK_VALID_BIT = 0;
	localparam int MASK_ADDR_LSB = 16;
	localparam logic [15:0] BASE_RESET = 16'h0000;
	localparam logic [31:0] MASK_RESET = 32'h0000_0000;
	localparam logic [12:0] CTRL_RESET = 13'h0000;
	localparam logic [3:0] PIN_RESET = 4'h0;
	localparam logic [BANK_COUNT-1:0] BANK_LSB = 8'h01;

	// ****************************************************************
	// Encodings
	// ****************************************************************
	localparam logic [1:0] WIDTH_LONG = 2'h0;
	localparam logic [1:0] WIDTH_BYTE = 2'h1;
	localparam logic [1:0] WIDTH_WORD = 2'h2;
	localparam logic [1:0] WIDTH_LINE = 2'h3;
	localparam logic [1:0] PORT_32 = 2'h0;
	localparam logic [1:0] PORT_8 = 2'h1;
	localparam logic [1:0] PORT_16 = 2'h2;

	typedef struct packed {
		logic [3:0] wait_count;
		logic [1:0] port_size;
		logic write_hold;
		logic read_hold;
		logic addr_setup;
		logic burst_en;
		logic foreign_master_auto_ack;
		logic write_en;
		logic read_en;
	} ctrl_t;

	typedef struct packed {
		logic [27:0] addr;
		logic rnw;
		logic [1:0] width;
	} req_t;

	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic logic [2:0] size_log2(input logic [1:0] width);
		case (width)
			WIDTH_BYTE: size_log2 = 3'h0;
			WIDTH_WORD: size_log2 = 3'h1;
			WIDTH_LINE: size_log2 = 3'h4;
			default: size_log2 = 3'h2;
		endcase
	endfunction

	function automatic logic [2:0] port_log2(input logic [1:0] port);
		case (port)
			PORT_8: port_log2 = 3'h0;
			PORT_16: port_log2 = 3'h1;
			default: port_log2 = 3'h2;
		endcase
	endfunction

	function automatic logic [4:0] beat_count(input logic [1:0] width,
		input logic [1:0] port, input logic burst);
		logic [2:0] lw;
		logic [2:0] lp;
		lw = size_log2(width);
		lp = port_log2(port);
		if (burst && lw > lp)
			beat_count = 5'(5'h01 << (lw - lp));
		else
			beat_count = 5'h01;
	endfunction

	// Bit 0 is the lane on the top data byte.
	function automatic logic [3:0] lane_enable(input logic [1:0] port,
		input logic [1:0] width, input logic [1:0] a);
		case (port)
			PORT_8: lane_enable = 4'h1;
			PORT_16: lane_enable = (width == WIDTH_BYTE) ? (a[0] ? 4'h2 : 4'h1) : 4'h3;
			default:
				if (width == WIDTH_BYTE)
					lane_enable = 4'(4'h1 << a);
				else if (width == WIDTH_WORD)
					lane_enable = a[1] ? 4'hc : 4'h3;
				else
					lane_enable = 4'hf;
		endcase
	endfunction

endpackage

// file: bank_decode.sv
/*
 Address match of a captured foreign address against the bank table.
 Assumes base and mask words come straight from the register file.
*/
`timescale 1ns/1ns
module bank_decode
	import chip_select_pkg::*;
(
	input wire logic [27:0] addr,
	input wire logic [BANK_COUNT-1:0][15:0] base,
	input wire logic [BANK_COUNT-1:0][31:0] mask,
	output logic hit,
	output logic [BANK_IDX_BITS-1:0] index
);
	logic [31:0] ext;

	// Only the address mask and valid bit take part; attribute masks are skipped.
	always_comb
	begin
		ext = {4'h0, addr};
		hit = 1'b0;
		index = '0;
		for (int i = BANK_COUNT - 1; i >= 0; i--)
		begin
			if (mask[i][MASK_VALID_BIT] &&
				(((ext[31:16] ^ base[i]) & ~mask[i][31:MASK_ADDR_LSB]) == 16'h0000))
			begin
				hit = 1'b1;
				index = BANK_IDX_BITS'(i);
			end
		end
	end
endmodule // bank_decode

// file: external_master_chip_select.sv
/*
 Chip-select decode, byte write strobes and automatic acknowledge for
 transfers run by another bus master.
 Assumes the arbiter drives bus_granted and a DRAM decoder drives dram_hit,
 both on core_clk; bus pins arrive asynchronously and are synchronised.
*/
// Our own choices: strobed register access and the register offsets.
// Function
// - While granted away, latch address, direction, width when transfer begin seen.
// - Upper address pins not used as address decode as zero.
// - Transfer kind and access attribute are ignored by the decode.
// - Attribute mask bits of the bank mask take no part in matching.
// - Control sequence starts on the edge after the capture edge.
// - Hit on direction-enabled bank asserts its select, and byte strobes on writes with nonzero wait.
// - Bank auto-ack set: drive acknowledge and assert it at wait time.
// - Address bus is never driven during foreign accesses.
// - Unmatched address uses fallback control; auto-ack after wait count clocks.
// - Burst enabled and width above port size gives burst sequence.
// - Decode in clock after capture; zero wait asserts select and ack next.
// - Clock after last acknowledged beat negates select and acknowledge.
// - One edge after that negation the acknowledge is released.
// - Zero-wait burst without setup or hold keeps select and acknowledge asserted.
// - Setup and hold options do nothing on nonburst accesses.
// - Burst reads: one negated clock per set setup and read hold bit.
// - Burst writes: select negated one clock per setup and write hold bit.
// - No byte write strobes on zero-wait writes.
`timescale 1ns/1ns
module external_master_chip_select
	import chip_select_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [31:0] reg_rdata,
	input wire logic bus_granted,
	input wire logic dram_hit,
	input wire logic transfer_begin_n,
	input wire logic [27:0] address,
	input wire logic read_not_write,
	input wire logic [1:0] transfer_width,
	input wire logic [1:0] transfer_kind,
	input wire logic access_attribute,
	input wire logic transfer_ack_in_n,
	output logic transfer_ack_out_n,
	output logic transfer_ack_oe,
	output logic address_oe,
	output logic [BANK_COUNT-1:0] bank_select_n,
	output logic [3:0] byte_write_strobe_n
);
	import chip_select_pkg::*;

	typedef enum logic [2:0] {IDLE, DECODE, ACTIVE, GAP, FINISH} state_t;

	logic [BANK_COUNT-1:0][15:0] base_q;
	logic [BANK_COUNT-1:0][31:0] mask_q;
	ctrl_t ctrl_q [BANK_COUNT];
	ctrl_t dflt_q;
	logic [3:0] pin_cfg_q;
	logic [31:0] rd_d;
	logic bank_area;
	logic [BANK_IDX_BITS-1:0] reg_bank;
	logic [3:0] reg_sub;

	req_t pin_m_q;
	req_t pin_s_q;
	logic ts_m_q;
	logic ts_s_q;
	logic ack_m_q;
	logic ack_s_q;

	state_t state_q;
	state_t state_d;
	req_t req_q;
	req_t req_d;
	ctrl_t cur_q;
	ctrl_t ctrl_d;
	logic hit_q;
	logic hit_d;
	logic [BANK_IDX_BITS-1:0] idx_q;
	logic [BANK_IDX_BITS-1:0] idx_d;
	logic [3:0] wait_q;
	logic [3:0] wait_d;
	logic [3:0] beats_q;
	logic [3:0] beats_d;
	logic [1:0] gap_q;
	logic [1:0] gap_d;
	logic [1:0] gap_len;
	logic beat_done;

	logic [27:0] dec_addr;
	logic dec_hit;
	logic [BANK_IDX_BITS-1:0] dec_idx;
	ctrl_t dec_ctrl;
	logic dec_go;

	// ****************************************************************
	// Register file
	// ****************************************************************
	assign bank_area = ~reg_addr[7];
	assign reg_bank = reg_addr[6:4];
	assign reg_sub = reg_addr[3:0];

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			base_q <= {BANK_COUNT{BASE_RESET}};
			mask_q <= {BANK_COUNT{MASK_RESET}};
			for (int i = 0; i < BANK_COUNT; i++)
				ctrl_q[i] <= ctrl_t'(CTRL_RESET);
			dflt_q <= ctrl_t'(CTRL_RESET);
			pin_cfg_q <= PIN_RESET;
		end
		else if (reg_write)
		begin
			if (bank_area && reg_sub == BASE_OFS)
				base_q[reg_bank] <= reg_wdata[15:0];
			if (bank_area && reg_sub == MASK_OFS)
				mask_q[reg_bank] <= reg_wdata;
			if (bank_area && reg_sub == CTRL_OFS)
				ctrl_q[reg_bank] <= ctrl_t'(reg_wdata[$bits(ctrl_t)-1:0]);
			if (reg_addr == DFLT_OFS)
				dflt_q <= ctrl_t'(reg_wdata[$bits(ctrl_t)-1:0]);
			if (reg_addr == PIN_OFS)
				pin_cfg_q <= reg_wdata[3:0];
		end
	end

	always_comb
	begin
		rd_d = 32'h0000_0000;
		if (bank_area)
		begin
			case (reg_sub)
				BASE_OFS: rd_d = 32'(base_q[reg_bank]);
				MASK_OFS: rd_d = mask_q[reg_bank];
				CTRL_OFS: rd_d = 32'(ctrl_q[reg_bank]);
				default: rd_d = 32'h0000_0000;
			endcase
		end
		else if (reg_addr == DFLT_OFS)
			rd_d = 32'(dflt_q);
		else if (reg_addr == PIN_OFS)
			rd_d = 32'(pin_cfg_q);
		else if (reg_addr == STATUS_OFS)
			rd_d = 32'({idx_q, hit_q, state_q != IDLE});
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
			reg_rdata <= 32'h0000_0000;
		else
			reg_rdata <= reg_read ? rd_d : 32'h0000_0000;
	end

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	// Transfer kind and access attribute are deliberately never sampled.
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			ts_m_q <= 1'b1;
			ts_s_q <= 1'b1;
			ack_m_q <= 1'b1;
			ack_s_q <= 1'b1;
			pin_m_q <= '0;
			pin_s_q <= '0;
		end
		else
		begin
			ts_m_q <= transfer_begin_n;
			ts_s_q <= ts_m_q;
			ack_m_q <= transfer_ack_in_n;
			ack_s_q <= ack_m_q;
			pin_m_q <= '{addr: address, rnw: read_not_write, width: transfer_width};
			pin_s_q <= pin_m_q;
		end
	end

	// ****************************************************************
	// Decode
	// ****************************************************************
	assign dec_addr = {pin_cfg_q & req_q.addr[27:24], req_q.addr[23:0]};

	bank_decode u_decode (
		.addr(dec_addr),
		.base(base_q),
		.mask(mask_q),
		.hit(dec_hit),
		.index(dec_idx)
	);

	always_comb
	begin
		dec_ctrl = dec_hit ? ctrl_q[dec_idx] : dflt_q;
		if (dec_hit)
			dec_go = req_q.rnw ? dec_ctrl.read_en : dec_ctrl.write_en;
		else
			dec_go = ~dram_hit & dflt_q.foreign_master_auto_ack;
	end

	assign beat_done = cur_q.foreign_master_auto_ack ? (wait_q == 4'h0) : ~ack_s_q;
	assign gap_len = {1'b0, cur_q.addr_setup} +
		{1'b0, req_q.rnw ? cur_q.read_hold : cur_q.write_hold};

	// ****************************************************************
	// Sequencer
	// ****************************************************************
	always_comb
	begin
		state_d = state_q;
		req_d = req_q;
		ctrl_d = cur_q;
		hit_d = hit_q;
		idx_d = idx_q;
		wait_d = wait_q;
		beats_d = beats_q;
		gap_d = gap_q;
		unique case (state_q)
			IDLE:
				if (bus_granted && !ts_s_q)
				begin
					req_d = pin_s_q;
					state_d = DECODE;
				end
			DECODE:
			begin
				ctrl_d = dec_ctrl;
				hit_d = dec_hit;
				idx_d = dec_idx;
				wait_d = dec_ctrl.wait_count;
				beats_d = 4'(beat_count(req_q.width, dec_ctrl.port_size,
					dec_ctrl.burst_en) - 5'h01);
				state_d = dec_go ? ACTIVE : IDLE;
			end
			ACTIVE:
			begin
				if (wait_q != 4'h0)
					wait_d = wait_q - 4'h1;
				if (beat_done)
				begin
					wait_d = cur_q.wait_count;
					if (beats_q == 4'h0)
						state_d = FINISH;
					else
					begin
						beats_d = beats_q - 4'h1;
						gap_d = gap_len;
						if (gap_len != 2'h0)
							state_d = GAP;
					end
				end
			end
			GAP:
			begin
				gap_d = gap_q - 2'h1;
				if (gap_q == 2'h1)
					state_d = ACTIVE;
			end
			FINISH:
				state_d = IDLE;
		endcase
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
			state_q <= IDLE;
		else
			state_q <= state_d;
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			req_q <= '0;
			cur_q <= ctrl_t'(CTRL_RESET);
			hit_q <= 1'b0;
			idx_q <= '0;
		end
		else
		begin
			req_q <= req_d;
			cur_q <= ctrl_d;
			hit_q <= hit_d;
			idx_q <= idx_d;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			wait_q <= 4'h0;
			beats_q <= 4'h0;
			gap_q <= 2'h0;
		end
		else
		begin
			wait_q <= wait_d;
			beats_q <= beats_d;
			gap_q <= gap_d;
		end
	end

	// ****************************************************************
	// Pin drivers
	// ****************************************************************
	// Select, acknowledge and strobe outputs are registered from next-state values so that they change
	// on the same edge as the sequencer; address_oe is tied low.
	assign address_oe = 1'b0;

	always_ff @(posedge core_clk)
	begin
		if (rst)
			bank_select_n <= {BANK_COUNT{1'b1}};
		else if (state_d == ACTIVE && hit_d)
			bank_select_n <= ~(BANK_LSB << idx_d);
		else
			bank_select_n <= {BANK_COUNT{1'b1}};
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			transfer_ack_out_n <= 1'b1;
			transfer_ack_oe <= 1'b0;
		end
		else
		begin
			transfer_ack_out_n <= ~(state_d == ACTIVE && ctrl_d.foreign_master_auto_ack &&
				wait_d == 4'h0);
			transfer_ack_oe <= ctrl_d.foreign_master_auto_ack &&
				(state_d == ACTIVE || state_d == GAP || state_d == FINISH);
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
			byte_write_strobe_n <= 4'hf;
		else if (state_d == ACTIVE && hit_d && !req_d.rnw && ctrl_d.wait_count != 4'h0)
			byte_write_strobe_n <= ~lane_enable(ctrl_d.port_size, req_d.width,
				req_d.addr[1:0]);
		else
			byte_write_strobe_n <= 4'hf;
	end
endmodule // external_master_chip_select

// file: chip_select_chk.sv
/*
 Port checker for the foreign-master chip-select block.
 Assumes it is bound to the design top by the bind below its module.
*/
`timescale 1ns/1ns
module chip_select_chk
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic bus_granted,
	input wire logic transfer_begin_n,
	input wire logic transfer_ack_out_n,
	input wire logic transfer_ack_oe,
	input wire logic address_oe,
	input wire logic [7:0] bank_select_n,
	input wire logic [3:0] byte_write_strobe_n
);
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (rst);

	property p_no_addr; address_oe == 1'b0; endproperty
	a_no_addr: assert property (p_no_addr) else $error("address bus driven");
	property p_one_bank; bank_select_n != 8'hff |-> $onehot(~bank_select_n); endproperty
	a_one_bank: assert property (p_one_bank) else $error("select not one-hot");
	property p_late; $fell(transfer_begin_n) |-> (bank_select_n == 8'hff) [*4]; endproperty
	a_late: assert property (p_late) else $error("select too early");
	property p_ack_drv; !transfer_ack_out_n |-> transfer_ack_oe; endproperty
	a_ack_drv: assert property (p_ack_drv) else $error("ack low undriven");
	property p_rel;
		$fell(transfer_ack_oe) |-> $past(transfer_ack_out_n) && $past(bank_select_n) == 8'hff;
	endproperty
	a_rel: assert property (p_rel) else $error("ack released too soon");
	property p_we0;
		bank_select_n != 8'hff && $past(bank_select_n) == 8'hff && !transfer_ack_out_n
			|-> byte_write_strobe_n == 4'hf;
	endproperty
	a_we0: assert property (p_we0) else $error("strobe on zero-wait write");
	property p_we_sel; byte_write_strobe_n != 4'hf |-> bank_select_n != 8'hff; endproperty
	a_we_sel: assert property (p_we_sel) else $error("strobe without select");
	property p_idle;
		!bus_granted [*6] |-> bank_select_n == 8'hff && !transfer_ack_oe;
	endproperty
	a_idle: assert property (p_idle) else $error("activity while not granted");

	c_fallback: cover property (!transfer_ack_out_n && bank_select_n == 8'hff);
	c_strobe: cover property (byte_write_strobe_n != 4'hf);
	c_gap: cover property (bank_select_n != 8'hff ##1 bank_select_n == 8'hff
		##1 bank_select_n != 8'hff);
endmodule // chip_select_chk

bind external_master_chip_select chip_select_chk i_chip_select_chk (.core_clk(core_clk),
	.rst(rst), .bus_granted(bus_granted), .transfer_begin_n(transfer_begin_n),
	.transfer_ack_out_n(transfer_ack_out_n), .transfer_ack_oe(transfer_ack_oe),
	.address_oe(address_oe), .bank_select_n(bank_select_n),
	.byte_write_strobe_n(byte_write_strobe_n));

// file: foreign_master_model.sv
/*
 Foreign bus master: starts a transfer on go and steps the address per beat.
 Assumes ack_n is the resolved acknowledge wire with its pull-up.
*/
`timescale 1ns/1ns
module foreign_master_model
(
	input wire logic core_clk,
	input wire logic go,
	input wire logic [27:0] req_addr,
	input wire logic req_rnw,
	input wire logic [1:0] req_width,
	input wire logic ack_n,
	output logic transfer_begin_n,
	output logic [27:0] address,
	output logic read_not_write,
	output logic [1:0] transfer_width
);
	initial
	begin
		transfer_begin_n = 1'b1;
		address = 28'h0;
		read_not_write = 1'b1;
		transfer_width = 2'h0;
	end
	always @(posedge core_clk)
	begin
		transfer_begin_n <= !go;
		if (go)
		begin
			address <= req_addr;
			read_not_write <= req_rnw;
			transfer_width <= req_width;
		end
		else if (!ack_n)
			address <= address + 28'h2;
	end
endmodule // foreign_master_model

// file: tb_external_master_chip_select.sv
/*
 Self-checking bench of the foreign-master chip-select block.
 Assumes the master model and the bound port checker are compiled first.
*/
`timescale 1ns/1ns
module tb_external_master_chip_select;
	logic core_clk, rst, reg_write, reg_read, bus_granted, dram_hit, go, req_rnw;
	logic transfer_begin_n, read_not_write, transfer_ack_out_n, transfer_ack_oe, address_oe;
	logic [7:0] reg_addr, bank_select_n;
	logic [31:0] reg_wdata, reg_rdata;
	logic [27:0] req_addr, address;
	logic [1:0] req_width, transfer_width;
	logic [3:0] byte_write_strobe_n;
	logic [1:0] transfer_kind;
	logic access_attribute;
	int failures, num_checks;
	wire ack_wire = transfer_ack_oe ? transfer_ack_out_n : 1'b1;

	external_master_chip_select i_external_master_chip_select (.core_clk(core_clk),
		.rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
		.reg_read(reg_read), .reg_rdata(reg_rdata), .bus_granted(bus_granted),
		.dram_hit(dram_hit), .transfer_begin_n(transfer_begin_n), .address(address),
		.read_not_write(read_not_write), .transfer_width(transfer_width),
		.transfer_kind(transfer_kind), .access_attribute(access_attribute),
		.transfer_ack_in_n(ack_wire),
		.transfer_ack_out_n(transfer_ack_out_n), .transfer_ack_oe(transfer_ack_oe),
		.address_oe(address_oe), .bank_select_n(bank_select_n),
		.byte_write_strobe_n(byte_write_strobe_n));
	foreign_master_model i_foreign_master_model (.core_clk(core_clk), .go(go),
		.req_addr(req_addr), .req_rnw(req_rnw), .req_width(req_width), .ack_n(ack_wire),
		.transfer_begin_n(transfer_begin_n), .address(address),
		.read_not_write(read_not_write), .transfer_width(transfer_width));

	task automatic complete_run();
		if (failures == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic ck(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e)
		begin
			failures++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge core_clk);
		reg_write <= 1'b0;
		@(posedge core_clk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge core_clk);
		reg_read <= 1'b0;
		#1;
		ck("reg_rdata", e, reg_rdata);
		@(posedge core_clk);
	endtask

	// ****************************************************************
	// One foreign transfer, measured from the cycle after the start pin
	// ****************************************************************
	task automatic xf(input logic [27:0] a, input logic rnw, input logic [1:0] w,
		input logic [7:0] es, input logic [3:0] est, input int eb, el, esp);
		logic [7:0] s;
		logic [3:0] st;
		int b, lat, f, l, n;
		bit seen;
		s = 8'hff;
		st = 4'hf;
		b = 0;
		lat = 0;
		f = -1;
		l = -2;
		seen = 0;
		req_addr <= a;
		req_rnw <= rnw;
		req_width <= w;
		go <= 1'b1;
		@(posedge core_clk);
		go <= 1'b0;
		for (n = 0; n < 40; n++)
		begin
			@(posedge core_clk);
			#1;
			s = s & bank_select_n;
			st = st & byte_write_strobe_n;
			if (ack_wire === 1'b0 && lat == 0)
				lat = n + 1;
			if (ack_wire === 1'b0)
				b++;
			if (bank_select_n != 8'hff && f < 0)
				f = n;
			if (bank_select_n != 8'hff)
				l = n;
			if (transfer_ack_oe === 1'b1)
				seen = 1;
			else if (seen || n == 15)
				break;
		end
		if (n == 40)
		begin
			failures++;
			complete_run();
		end
		ck("select", es, s);
		ck("strobe", est, st);
		ck("beats", eb, b);
		ck("latency", el, lat);
		ck("span", esp, l - f + 1);
	endtask

	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	initial
	begin
		failures = 0;
		num_checks = 0;
		rst = 1'b1;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		reg_write = 1'b0;
		reg_read = 1'b0;
		bus_granted = 1'b1;
		dram_hit = 1'b0;
		go = 1'b0;
		req_addr = 28'h0;
		req_rnw = 1'b1;
		req_width = 2'h0;
		transfer_kind = 2'h3;
		access_attribute = 1'b1;
		repeat (6) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		rd(8'h80, 32'h0);
		wr(8'h8c, 32'hffffffff);
		rd(8'h8c, 32'h0);
		wr(8'h00, 32'h1);
		wr(8'h04, 32'h3f);
		wr(8'h08, 32'h7);
		wr(8'h10, 32'h20);
		wr(8'h14, 32'h1);
		wr(8'h18, 32'h10d);
		rd(8'h08, 32'h7);
		xf(28'h5010000, 1, 2'h0, 8'hfe, 4'hf, 1, 4, 1);
		transfer_kind <= 2'h0;
		access_attribute <= 1'b0;
		xf(28'h0010000, 0, 2'h0, 8'hfe, 4'hf, 1, 4, 1);
		wr(8'h08, 32'h207);
		xf(28'h0010001, 0, 2'h1, 8'hfe, 4'hd, 1, 5, 2);
		xf(28'h0200000, 1, 2'h0, 8'hfd, 4'hf, 2, 4, 2);
		xf(28'h0200000, 0, 2'h0, 8'hff, 4'hf, 0, 0, 0);
		wr(8'h18, 32'h11d);
		xf(28'h0200000, 1, 2'h0, 8'hfd, 4'hf, 2, 4, 3);
		xf(28'h0200001, 1, 2'h1, 8'hfd, 4'hf, 1, 4, 1);
		wr(8'h18, 32'h13d);
		xf(28'h0200000, 1, 2'h0, 8'hfd, 4'hf, 2, 4, 4);
		wr(8'h18, 32'h14f);
		xf(28'h0200000, 0, 2'h0, 8'hfd, 4'hf, 2, 4, 3);
		xf(28'h0300000, 1, 2'h2, 8'hff, 4'hf, 0, 0, 0);
		wr(8'h80, 32'h404);
		xf(28'h0300000, 1, 2'h2, 8'hff, 4'hf, 1, 6, 0);
		dram_hit <= 1'b1;
		xf(28'h0300000, 1, 2'h2, 8'hff, 4'hf, 0, 0, 0);
		dram_hit <= 1'b0;
		bus_granted <= 1'b0;
		xf(28'h0010000, 1, 2'h0, 8'hff, 4'hf, 0, 0, 0);
		complete_run();
	end
endmodule // tb_external_master_chip_select
